// ### edma_engine.v
// Seven-channel DMA engine with bus ownership arbitration
`timescale 1ns/1ps
`default_nettype none
`include "edma_map.vh"
module edma_engine #(
  parameter TIMEOUT_CYC = (`EDMA_TIMEOUT_NS + `EDMA_CLK_NS - 1) / `EDMA_CLK_NS
) (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] dreq,
  input wire [7:0] sw_req,
  input wire end_of_process_in,
  input wire master16_n,
  input wire eisa_mreq,
  input wire pci_req,
  input wire refresh_req,
  input wire cfg_we,
  input wire [2:0] cfg_ch,
  input wire [1:0] cfg_mode,
  input wire [1:0] cfg_xfer,
  input wire [1:0] cfg_timing,
  input wire cfg_word,
  input wire cfg_addr32,
  input wire cfg_decr,
  input wire cfg_autoinit,
  input wire cfg_chain,
  input wire [31:0] cfg_addr,
  input wire [23:0] cfg_count,
  input wire [31:0] cfg_stop,
  input wire cfg_stop_en,
  input wire [7:0] sel_ch_oh,
  output reg [7:0] dack_r,
  output reg [31:0] bus_addr_r,
  output reg addr_oe_r,
  output reg iorc_n_r,
  output reg iowc_n_r,
  output reg m_io_r,
  output reg w_r_r,
  output reg terminal_count_r,
  output reg [7:0] tc_status_r,
  output reg eisa_mack_r,
  output reg pci_gnt_r,
  output reg refresh_r,
  output reg [15:0] refresh_addr_r,
  output reg master_mode_r,
  output reg [31:0] cur_addr_rd_r,
  output reg [23:0] cur_count_rd_r
);
  localparam ST_IDLE = 3'h0;
  localparam ST_XFER = 3'h1;
  localparam ST_CASC = 3'h2;
  localparam ST_OTHER = 3'h3;
  localparam ST_REL = 3'h4;
  localparam [15:0] TO_CYC = TIMEOUT_CYC[15:0];

  reg [1:0] mode_r [0:7];
  reg [1:0] xfer_r [0:7];
  reg [1:0] tim_r [0:7];
  reg word_r [0:7];
  reg a32_r [0:7];
  reg decr_r [0:7];
  reg auto_r [0:7];
  reg chain_r [0:7];
  reg stop_en_r [0:7];
  reg [31:0] addr_r [0:7];
  reg [23:0] cnt_r [0:7];
  reg [31:0] base_addr_r [0:7];
  reg [23:0] base_cnt_r [0:7];
  reg [31:0] stop_r [0:7];
  reg [7:0] dreq_r;
  reg eop_r;
  reg [7:0] swreq_r;
  reg [2:0] state_r;
  reg [2:0] ch_r;
  reg [3:0] cyc_r;
  reg first_r;
  reg [15:0] tout_r;
  reg [31:0] step_addr;
  reg [23:0] step_cnt;
  reg tc_hit;
  wire [7:0] req_all;
  wire [2:0] win;
  wire win_any;
  integer k;

  // Timing length per cycle; first transfer is the longer one
  function [3:0] cyc_len;
    input [1:0] tim;
    input first;
    begin
      case (tim)
        `EDMA_TIM_COMPAT: cyc_len = first ? `EDMA_CLK_COMPAT_FIRST : `EDMA_CLK_COMPAT_REP;
        `EDMA_TIM_TYPEA: cyc_len = first ? `EDMA_CLK_A_FIRST : `EDMA_CLK_A_REP;
        `EDMA_TIM_TYPEB: cyc_len = first ? `EDMA_CLK_B_FIRST : `EDMA_CLK_B_REP;
        default: cyc_len = first ? `EDMA_CLK_C_FIRST : `EDMA_CLK_C_REP;
      endcase
    end
  endfunction

  // ********************************
  // Input registering
  // ********************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      dreq_r <= 8'h00;
      eop_r <= 1'b0;
    end else begin
      dreq_r <= dreq;
      eop_r <= end_of_process_in | (eop_r & (state_r == ST_XFER));
    end
  end

  assign req_all = dreq_r | swreq_r;

  edma_prio u_prio (
    .req(req_all),
    .win(win),
    .any(win_any)
  );

  // ********************************
  // Next address and count for the active channel
  // ********************************
  always @* begin
    step_addr = addr_r[ch_r];
    step_cnt = cnt_r[ch_r] - 24'h000001;
    if (a32_r[ch_r]) begin
      step_addr = decr_r[ch_r] ? addr_r[ch_r] - 32'h00000001 : addr_r[ch_r] + 32'h00000001;
    end else begin
      step_addr[15:0] = decr_r[ch_r] ? addr_r[ch_r][15:0] - 16'h0001 : addr_r[ch_r][15:0] + 16'h0001;
    end
    // End input is held through the transfer so a short pulse is not lost
    tc_hit = (cnt_r[ch_r] == `EDMA_CNT_ZERO) || eop_r;
    if (stop_en_r[ch_r] && (addr_r[ch_r] == stop_r[ch_r])) begin
      tc_hit = 1'b1;
    end
  end

  // ********************************
  // Main sequencer
  // ********************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      for (k = 0; k < `EDMA_NCH; k = k + 1) begin
        mode_r[k] <= (k == 4) ? `EDMA_MODE_CASCADE : `EDMA_MODE_SINGLE;
        xfer_r[k] <= `EDMA_XFER_VERIFY;
        tim_r[k] <= `EDMA_TIM_COMPAT;
        word_r[k] <= (k > 4);
        a32_r[k] <= 1'b0;
        decr_r[k] <= 1'b0;
        auto_r[k] <= 1'b0;
        chain_r[k] <= 1'b0;
        stop_en_r[k] <= 1'b0;
        addr_r[k] <= 32'h00000000;
        cnt_r[k] <= 24'h000000;
        base_addr_r[k] <= 32'h00000000;
        base_cnt_r[k] <= 24'h000000;
        stop_r[k] <= 32'h00000000;
      end
      swreq_r <= 8'h00;
      state_r <= ST_IDLE;
      ch_r <= 3'h0;
      cyc_r <= 4'h0;
      first_r <= 1'b1;
      tout_r <= 16'h0000;
      dack_r <= 8'h00;
      bus_addr_r <= 32'h00000000;
      addr_oe_r <= 1'b0;
      iorc_n_r <= 1'b1;
      iowc_n_r <= 1'b1;
      m_io_r <= 1'b0;
      w_r_r <= 1'b0;
      terminal_count_r <= 1'b0;
      tc_status_r <= 8'h00;
      eisa_mack_r <= 1'b0;
      pci_gnt_r <= 1'b0;
      refresh_r <= 1'b0;
      refresh_addr_r <= 16'h0000;
      master_mode_r <= 1'b0;
      cur_addr_rd_r <= 32'h00000000;
      cur_count_rd_r <= 24'h000000;
    end else begin
      terminal_count_r <= 1'b0;
      cur_addr_rd_r <= addr_r[cfg_ch];
      cur_count_rd_r <= cnt_r[cfg_ch];
      // Slave side: programming a channel, channel four stays cascade
      if (cfg_we && (cfg_ch != `EDMA_CASCADE_CH)) begin
        mode_r[cfg_ch] <= cfg_mode;
        xfer_r[cfg_ch] <= cfg_xfer;
        tim_r[cfg_ch] <= cfg_timing;
        word_r[cfg_ch] <= cfg_word;
        a32_r[cfg_ch] <= cfg_addr32;
        decr_r[cfg_ch] <= cfg_decr;
        auto_r[cfg_ch] <= cfg_autoinit;
        chain_r[cfg_ch] <= cfg_chain;
        stop_en_r[cfg_ch] <= cfg_stop_en;
        stop_r[cfg_ch] <= cfg_stop;
        addr_r[cfg_ch] <= cfg_addr;
        cnt_r[cfg_ch] <= cfg_count;
        base_addr_r[cfg_ch] <= cfg_addr;
        base_cnt_r[cfg_ch] <= cfg_count;
      end
      // Set wins over the clear at terminal count
      swreq_r <= swreq_r | (sw_req & 8'hEF);
      tc_status_r <= tc_status_r & ~sel_ch_oh;
      case (state_r)
        ST_IDLE: begin
          master_mode_r <= 1'b0;
          // DMA channels ahead of refresh, EISA masters, then PCI
          if (win_any) begin
            ch_r <= win;
            master_mode_r <= 1'b1;
            first_r <= 1'b1;
            tout_r <= 16'h0000;
            if (mode_r[win] == `EDMA_MODE_CASCADE) begin
              state_r <= ST_CASC;
            end else begin
              state_r <= ST_XFER;
              cyc_r <= 4'h0;
            end
          end else if (refresh_req) begin
            refresh_r <= 1'b1;
            bus_addr_r <= {16'h0000, refresh_addr_r};
            addr_oe_r <= 1'b1;
            refresh_addr_r <= refresh_addr_r + 16'h0001;
            master_mode_r <= 1'b1;
            state_r <= ST_OTHER;
          end else if (eisa_mreq) begin
            eisa_mack_r <= 1'b1;
            master_mode_r <= 1'b1;
            state_r <= ST_OTHER;
          end else if (pci_req) begin
            pci_gnt_r <= 1'b1;
            state_r <= ST_OTHER;
          end
        end
        ST_XFER: begin
          tout_r <= tout_r + 16'h0001;
          if (cyc_r == 4'h0) begin
            dack_r <= 8'h01 << ch_r;
            // Word channels put the word address out shifted
            bus_addr_r <= word_r[ch_r] ? {addr_r[ch_r][30:0], 1'b0} : addr_r[ch_r];
            addr_oe_r <= (xfer_r[ch_r] != `EDMA_XFER_VERIFY);
            // Verify drives no commands, only acknowledge
            iorc_n_r <= ~(xfer_r[ch_r] == `EDMA_XFER_WRITE);
            iowc_n_r <= ~(xfer_r[ch_r] == `EDMA_XFER_READ);
            m_io_r <= (xfer_r[ch_r] != `EDMA_XFER_VERIFY);
            w_r_r <= (xfer_r[ch_r] == `EDMA_XFER_WRITE);
          end
          if (cyc_r == cyc_len(xfer_r[ch_r] == `EDMA_XFER_VERIFY ? `EDMA_TIM_COMPAT : tim_r[ch_r],
                               first_r) - 4'h1) begin
            cyc_r <= 4'h0;
            first_r <= 1'b0;
            iorc_n_r <= 1'b1;
            iowc_n_r <= 1'b1;
            addr_r[ch_r] <= step_addr;
            cnt_r[ch_r] <= step_cnt;
            if (tc_hit) begin
              terminal_count_r <= 1'b1;
              tc_status_r[ch_r] <= 1'b1;
              swreq_r[ch_r] <= sw_req[ch_r];
              if (auto_r[ch_r] || chain_r[ch_r]) begin
                addr_r[ch_r] <= base_addr_r[ch_r];
                cnt_r[ch_r] <= base_cnt_r[ch_r];
              end
              state_r <= ST_REL;
            end else if (mode_r[ch_r] == `EDMA_MODE_SINGLE) begin
              swreq_r[ch_r] <= sw_req[ch_r];
              state_r <= ST_REL;
            end else if (mode_r[ch_r] == `EDMA_MODE_DEMAND && !req_all[ch_r]) begin
              state_r <= ST_REL;
            end else if (mode_r[ch_r] == `EDMA_MODE_BLOCK && tim_r[ch_r] != `EDMA_TIM_COMPAT &&
                         tout_r >= TO_CYC && (refresh_req || eisa_mreq || pci_req)) begin
              state_r <= ST_REL;
            end
            // Block continues regardless of request level
          end else begin
            cyc_r <= cyc_r + 4'h1;
          end
        end
        ST_CASC: begin
          // External master owns the bus until it drops its request and releases master16
          addr_oe_r <= 1'b0;
          dack_r <= 8'h01 << ch_r;
          if (!dreq_r[ch_r] && master16_n) begin
            state_r <= ST_REL;
          end
        end
        ST_OTHER: begin
          if ((refresh_r && !refresh_req) || (eisa_mack_r && !eisa_mreq) || (pci_gnt_r && !pci_req)) begin
            state_r <= ST_REL;
          end
        end
        default: begin
          dack_r <= 8'h00;
          addr_oe_r <= 1'b0;
          iorc_n_r <= 1'b1;
          iowc_n_r <= 1'b1;
          m_io_r <= 1'b0;
          w_r_r <= 1'b0;
          refresh_r <= 1'b0;
          eisa_mack_r <= 1'b0;
          pci_gnt_r <= 1'b0;
          master_mode_r <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // edma_engine
`default_nettype wire

// ### edma_map.vh
// Constants for the seven-channel DMA engine
`ifndef EDMA_MAP_VH
`define EDMA_MAP_VH
// ********************************
// Modes and transfer types
// ********************************
`define EDMA_MODE_SINGLE 2'h0
`define EDMA_MODE_BLOCK 2'h1
`define EDMA_MODE_DEMAND 2'h2
`define EDMA_MODE_CASCADE 2'h3
`define EDMA_XFER_VERIFY 2'h0
`define EDMA_XFER_WRITE 2'h1
`define EDMA_XFER_READ 2'h2
// ********************************
// Timings in bus clocks
// ********************************
`define EDMA_TIM_COMPAT 2'h0
`define EDMA_TIM_TYPEA 2'h1
`define EDMA_TIM_TYPEB 2'h2
`define EDMA_TIM_TYPEC 2'h3
`define EDMA_CLK_COMPAT_FIRST 4'h9
`define EDMA_CLK_COMPAT_REP 4'h8
`define EDMA_CLK_A_FIRST 4'h7
`define EDMA_CLK_A_REP 4'h6
`define EDMA_CLK_B_FIRST 4'h6
`define EDMA_CLK_B_REP 4'h4
`define EDMA_CLK_C_FIRST 4'h2
`define EDMA_CLK_C_REP 4'h1
// ********************************
// Channel layout and counters
// ********************************
`define EDMA_NCH 8
`define EDMA_CASCADE_CH 3'h4
`define EDMA_CNT_ALL1 24'hFFFFFF
`define EDMA_CNT_ZERO 24'h000000
`define EDMA_TIMEOUT_NS 4000
`define EDMA_CLK_NS 10
`endif

// ### edma_prio.v
// Fixed-priority channel picker for the DMA engine
`timescale 1ns/1ps
`default_nettype none
module edma_prio (
  input wire [7:0] req,
  output reg [2:0] win,
  output reg any
);
  integer i;
  // ********************************
  // Rank 0,1,2,3,5,6,7; a request on channel 4 is never picked
  // ********************************
  always @* begin
    win = 3'h0;
    any = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (req[i] && (i != 4)) begin
        win = i[2:0];
        any = 1'b1;
      end
    end
  end
endmodule // edma_prio
`default_nettype wire

// ### edma_checker.sv
// Port checker for the DMA engine
`timescale 1ns/1ps
`default_nettype none
module edma_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] dack_r,
  input wire logic addr_oe_r,
  input wire logic iorc_n_r,
  input wire logic iowc_n_r,
  input wire logic m_io_r,
  input wire logic w_r_r,
  input wire logic terminal_count_r,
  input wire logic eisa_mack_r,
  input wire logic pci_gnt_r,
  input wire logic refresh_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ****************
  // Bus ownership
  // ****************
  sequence s_release;
    $fell(|dack_r);
  endsequence
  sequence s_io_read_cmd;
    !iorc_n_r;
  endsequence
  a_ack_one_hot: assert property ($onehot0(dack_r)) else $error("two acknowledges at once");
  a_link_ch_quiet: assert property (!dack_r[4]) else $error("link channel acknowledged");
  a_write_cmd_shape: assert property (s_io_read_cmd |-> iowc_n_r && m_io_r && w_r_r && addr_oe_r && |dack_r)
    else $error("write transfer command malformed");
  a_read_cmd_shape: assert property (!iowc_n_r |-> iorc_n_r && m_io_r && !w_r_r && addr_oe_r && |dack_r)
    else $error("read transfer command malformed");
  a_tc_one_pulse: assert property (terminal_count_r |=> !terminal_count_r) else $error("terminal count too long");
  a_owner_unique: assert property ($onehot0({|dack_r, eisa_mack_r, pci_gnt_r, refresh_r}))
    else $error("two bus owners");
  a_release_gap: assert property (s_release |=> dack_r == 8'h00) else $error("no release cycle");
  a_grant_bus_quiet: assert property ((eisa_mack_r || pci_gnt_r) |-> !addr_oe_r && iorc_n_r && iowc_n_r)
    else $error("engine drives bus while granted away");
endmodule // edma_checker
bind edma_engine edma_checker u_chk (.mclk, .rst_n, .dack_r, .addr_oe_r, .iorc_n_r, .iowc_n_r, .m_io_r, .w_r_r,
  .terminal_count_r, .eisa_mack_r, .pci_gnt_r, .refresh_r);
`default_nettype wire

// ### edma_dev_model.sv
// Far-side model: DMA slave devices and a cascaded bus master
`timescale 1ns/1ps
`default_nettype none
module edma_dev_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] go,
  input wire logic keep,
  input wire logic [7:0] cas,
  input wire logic [7:0] dack,
  output logic [7:0] dreq,
  output logic master16_n
);
  logic [2:0] hold_r;
  // ****************
  // Requests and master hold
  // ****************
  always @(posedge mclk) begin
    if (!rst_n) begin
      dreq <= 8'h00;
      master16_n <= 1'b1;
      hold_r <= 3'h0;
    end else begin
      // A device with more data keeps asking, so single mode must still let go
      dreq <= (dreq | go) & ~(dack & {8{~keep}});
      if (|(dack & cas & dreq)) begin
        master16_n <= 1'b0;
        hold_r <= 3'h6;
      end else if (hold_r != 3'h0) begin
        hold_r <= hold_r - 3'h1;
        if (hold_r == 3'h1)
          master16_n <= 1'b1;
      end
    end
  end
endmodule // edma_dev_model
`default_nettype wire

// ### tb_edma_engine.sv
// Self-checking bench for the DMA engine
`timescale 1ns/1ps
`default_nettype none
`include "edma_map.vh"
module tb_edma_engine;
  typedef struct packed {
    logic [2:0] ch;
    logic [1:0] xf;
    logic [1:0] tm;
    logic [2:0] a32_dc_sw;
    logic [31:0] ad;
    logic [31:0] bus;
    logic [31:0] nxt;
    logic [4:0] len;
  } edma_row_t;
  localparam int TO = 20;
  logic mclk = 1'b0, rst_n = 1'b0, cfg_we = 1'b0, cfg_word = 1'b0, cfg_addr32 = 1'b0, cfg_decr = 1'b0;
  logic end_of_process_in = 1'b0, eisa_mreq = 1'b0, pci_req = 1'b0, keep = 1'b0, eop_arm = 1'b0, mreq_arm = 1'b0;
  logic [7:0] sw_req = 8'h00, sel_ch_oh = 8'h00, go = 8'h00, cas = 8'h00, dreq, dack_r, tc_status_r, dk_q, first_dk;
  logic [2:0] cfg_ch = 3'h0;
  logic [1:0] cfg_mode = 2'h0, cfg_xfer = 2'h0, cfg_timing = 2'h0;
  logic [31:0] cfg_addr = 32'h0, bus_addr_r, cur_addr_rd_r, first_addr;
  logic [23:0] cfg_count = 24'h0, cur_count_rd_r;
  logic master16_n, addr_oe_r, iorc_n_r, iowc_n_r, terminal_count_r, eisa_mack_r, pci_gnt_r;
  logic refresh_req = 1'b0, refresh_r, master_mode_r;
  logic [15:0] refresh_addr_r;
  int n_fail = 0, check_count = 0, dk_cyc, pulses, n_rd, n_wr, n_oe, n_tc, i;
  edma_row_t r;
  edma_row_t rows [7] = '{
    '{3'h0, 2'h1, 2'h0, 3'h0, 32'hA1B2C3D4, 32'hA1B2C3D4, 32'hA1B2C3D5, 5'h09},
    '{3'h1, 2'h2, 2'h1, 3'h6, 32'h00130000, 32'h00130000, 32'h0012FFFF, 5'h07},
    '{3'h2, 2'h0, 2'h2, 3'h1, 32'h0012FFFF, 32'h0012FFFF, 32'h00120000, 5'h09},
    '{3'h3, 2'h1, 2'h2, 3'h4, 32'h0012FFFF, 32'h0012FFFF, 32'h00130000, 5'h06},
    '{3'h5, 2'h2, 2'h3, 3'h0, 32'h00000100, 32'h00000200, 32'h00000101, 5'h02},
    '{3'h6, 2'h1, 2'h1, 3'h3, 32'h00000081, 32'h00000102, 32'h00000080, 5'h07},
    '{3'h7, 2'h0, 2'h0, 3'h0, 32'h00000040, 32'h00000080, 32'h00000041, 5'h09}};
  edma_dev_model u_dev (.mclk, .rst_n, .go, .keep, .cas, .dack(dack_r), .dreq, .master16_n);
  edma_engine #(.TIMEOUT_CYC(TO)) DUT (.mclk, .rst_n, .dreq, .sw_req, .end_of_process_in, .master16_n, .eisa_mreq,
    .pci_req, .refresh_req, .cfg_we, .cfg_ch, .cfg_mode, .cfg_xfer, .cfg_timing, .cfg_word, .cfg_addr32,
    .cfg_decr, .cfg_autoinit(1'b0), .cfg_chain(1'b0), .cfg_addr, .cfg_count, .cfg_stop(32'h0), .cfg_stop_en(1'b0),
    .sel_ch_oh, .dack_r, .bus_addr_r, .addr_oe_r, .iorc_n_r, .iowc_n_r, .m_io_r(), .w_r_r(), .terminal_count_r,
    .tc_status_r, .eisa_mack_r, .pci_gnt_r, .refresh_r, .refresh_addr_r, .master_mode_r, .cur_addr_rd_r,
    .cur_count_rd_r);
  // ****************
  // Clock, monitor and tasks
  // ****************
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (dack_r != 8'h00 && dk_q == 8'h00) begin
      if (pulses == 0) first_dk = dack_r;
      pulses++;
    end
    dk_q = dack_r;
    dk_cyc += (dack_r != 8'h00);
    n_rd += !iorc_n_r;
    n_wr += !iowc_n_r;
    if (addr_oe_r && n_oe == 0) first_addr = bus_addr_r;
    n_oe += addr_oe_r;
    n_tc += terminal_count_r;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic cfg(input logic [2:0] ch, input logic [1:0] md, xf, tm, input logic [1:0] a32dc,
                     input logic [31:0] ad, input logic [23:0] cn);
    @(negedge mclk);
    {cfg_ch, cfg_mode, cfg_xfer, cfg_timing, cfg_addr32, cfg_decr} = {ch, md, xf, tm, a32dc};
    {cfg_word, cfg_addr, cfg_count, cfg_we} = {ch[2], ad, cn, 1'b1};
    @(negedge mclk);
    cfg_we = 1'b0;
  endtask
  task automatic run(input logic [7:0] hw, input logic [7:0] sw, input int lim);
    @(negedge mclk);
    {dk_cyc, pulses, n_rd, n_wr, n_oe, n_tc} = '0;
    {go, sw_req} = {hw, sw};
    @(negedge mclk);
    {go, sw_req} = 16'h0000;
    for (i = 0; i < lim; i++) begin
      @(negedge mclk);
      end_of_process_in = (i == 6) && eop_arm;
      if (i == 6 && mreq_arm) {eisa_mreq, pci_req} = 2'h3;
      if (pulses > 0 && dack_r == 8'h00 && dreq == 8'h00 && master16_n) break;
    end
  endtask
  task automatic rdback(input logic [2:0] ch, input logic [31:0] ea, input logic [23:0] ec);
    @(negedge mclk);
    cfg_ch = ch;
    repeat (2) @(negedge mclk);
    chk(cur_addr_rd_r, ea);
    chk(32'(cur_count_rd_r), 32'(ec));
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    foreach (rows[k]) begin
      r = rows[k];
      cfg(r.ch, `EDMA_MODE_SINGLE, r.xf, r.tm, r.a32_dc_sw[2:1], r.ad, 24'h000010);
      run(r.a32_dc_sw[0] ? 8'h00 : 8'h01 << r.ch, r.a32_dc_sw[0] ? 8'h01 << r.ch : 8'h00, 40);
      chk(dk_cyc, 32'(r.len));
      chk(pulses, 1);
      chk(32'(n_rd != 0), 32'(r.xf == `EDMA_XFER_WRITE));
      chk(32'(n_wr != 0), 32'(r.xf == `EDMA_XFER_READ));
      if (r.xf != `EDMA_XFER_VERIFY) chk(first_addr, r.bus);
      rdback(r.ch, r.nxt, 24'h00000F);
    end
    run(8'h0A, 8'h00, 60);
    chk(32'(first_dk), 32'h02);
    run(8'h28, 8'h00, 60);
    chk(32'(first_dk), 32'h08);
    // Device drops its request after each acknowledge, so demand mode pauses and resumes
    cfg(3'h3, `EDMA_MODE_DEMAND, `EDMA_XFER_WRITE, `EDMA_TIM_TYPEB, 2'h0, 32'h00000200, 24'h000010);
    repeat (2) run(8'h08, 8'h00, 40);
    chk(dk_cyc, 6);
    rdback(3'h3, 32'h00000202, 24'h00000E);
    cfg(3'h0, `EDMA_MODE_BLOCK, `EDMA_XFER_WRITE, `EDMA_TIM_COMPAT, 2'h0, 32'h00000010, 24'h000002);
    run(8'h01, 8'h00, 60);
    chk(dk_cyc, 25);
    chk(n_tc, 1);
    chk(32'(tc_status_r[0]), 1);
    rdback(3'h0, 32'h00000013, 24'hFFFFFF);
    sel_ch_oh = 8'h01;
    @(negedge mclk);
    sel_ch_oh = 8'h00;
    repeat (2) @(negedge mclk);
    chk(32'(tc_status_r[0]), 0);
    cfg(3'h1, `EDMA_MODE_BLOCK, `EDMA_XFER_READ, `EDMA_TIM_TYPEB, 2'h0, 32'h0, 24'h000100);
    eop_arm = 1'b1;
    run(8'h02, 8'h00, 80);
    eop_arm = 1'b0;
    chk(n_tc, 1);
    chk(32'(dk_cyc < 40), 1);
    // Other owners join only once the block is under way, else they would simply win first
    cfg(3'h2, `EDMA_MODE_BLOCK, `EDMA_XFER_WRITE, `EDMA_TIM_TYPEA, 2'h0, 32'h0, 24'h000FFF);
    mreq_arm = 1'b1;
    run(8'h04, 8'h00, 90);
    mreq_arm = 1'b0;
    chk(32'(dk_cyc < TO + 30), 1);
    for (i = 0; i < 10 && eisa_mack_r !== 1'b1; i++) @(negedge mclk);
    chk(32'(eisa_mack_r), 1);
    eisa_mreq = 1'b0;
    for (i = 0; i < 10 && pci_gnt_r !== 1'b1; i++) @(negedge mclk);
    chk(32'(pci_gnt_r), 1);
    pci_req = 1'b0;
    cfg(3'h7, `EDMA_MODE_CASCADE, `EDMA_XFER_WRITE, `EDMA_TIM_COMPAT, 2'h0, 32'h0, 24'h0);
    cas = 8'h80;
    run(8'h80, 8'h00, 60);
    chk(pulses, 1);
    chk(n_oe + n_rd + n_wr, 0);
    chk(32'(dk_cyc >= 6), 1);
    cfg(3'h4, `EDMA_MODE_SINGLE, `EDMA_XFER_WRITE, `EDMA_TIM_COMPAT, 2'h0, 32'h0, 24'h10);
    run(8'h10, 8'h10, 12);
    chk(pulses, 0);
    cfg(3'h0, `EDMA_MODE_SINGLE, `EDMA_XFER_WRITE, `EDMA_TIM_COMPAT, 2'h0, 32'h0, 24'h000010);
    keep = 1'b1;
    run(8'h01, 8'h00, 40);
    chk(32'(pulses >= 2), 1);
    @(negedge mclk);
    rst_n = 1'b0;
    keep = 1'b0;
    repeat (16) @(negedge mclk);
    chk({dack_r, tc_status_r, 6'h00, iorc_n_r, iowc_n_r}, 32'h00000003);
    rst_n = 1'b1;
    run(8'h00, 8'h20, 40);
    chk(dk_cyc, 9);
    chk(n_rd + n_wr, 0);
    repeat (2) begin
      refresh_req = 1'b1;
      for (i = 0; i < 10 && refresh_r !== 1'b1; i++) @(negedge mclk);
      chk({30'h0, refresh_r, master_mode_r}, 32'h00000003);
      refresh_req = 1'b0;
      repeat (4) @(negedge mclk);
    end
    chk(bus_addr_r, 32'h00000001);
    chk(32'(refresh_addr_r), 32'h00000002);
    wrap_up();
  end
endmodule // tb_edma_engine
`default_nettype wire
